/* File: src/rsrec_map.svh */
// Register offsets, field positions, reset values and timing counts of the reset source recorder
`ifndef RSREC_MAP_SVH
`define RSREC_MAP_SVH

`define RSREC_OFS_CAUSE 12'h004
`define RSREC_OFS_BRC1 12'h008
`define RSREC_OFS_BRC2 12'h00C
`define RSREC_OFS_HYSA 12'h030
`define RSREC_OFS_HYSB 12'h034
`define RSREC_OFS_PFA 12'h038
`define RSREC_OFS_PFB 12'h03C
`define RSREC_OFS_WAKE 12'h054
`define RSREC_OFS_IRQ_STAT 12'h080
`define RSREC_OFS_IRQ_MASK 12'h084
`define RSREC_OFS_KEY 12'h100
`define RSREC_OFS_TRIM 12'h110

`define RSREC_BIT_CORE 0
`define RSREC_BIT_WDT 2
`define RSREC_BIT_SYSREQ 5
`define RSREC_BIT_PMU 6
`define RSREC_BIT_KERNEL 7
`define RSREC_BIT_CHIP_SHOT 0
`define RSREC_BIT_KERNEL_SHOT 1

`define RSREC_CAUSE_MASK 8'hE5
`define RSREC_BRC1_MASK 32'h0000_0007
`define RSREC_RST_ZERO 32'h0000_0000
`define RSREC_RST_WAKE 32'h0000_0006
`define RSREC_RST_TRIM 32'h0000_0000
`define RSREC_SHOT_CYCLES 2

`endif

/* File: src/rsrec_pkg.sv */
// Types shared by the reset source recorder
`default_nettype none
package rsrec_pkg;
  typedef enum logic [1:0] {
    rsrec_idle,
    rsrec_write_done,
    rsrec_read_done
  } rsrec_bus_type;
endpackage : rsrec_pkg
`default_nettype wire

/* File: src/rsrec_one_shot.sv */
// One-shot pulse that self-clears a fixed number of cycles after being fired
`default_nettype none
module rsrec_one_shot #(
  parameter int CYCLES = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic fire_i,
  output logic active_o
);
  localparam int CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
  logic [CW-1:0] count;

  initial begin
    if (CYCLES < 1) begin
      $error("rsrec_one_shot: CYCLES must be at least 1");
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count <= '0;
    end else if (enable_i) begin
      if (fire_i) begin
        count <= CW'(CYCLES);
      end else if (count != '0) begin
        count <= count - CW'(1);
      end
    end
  end

  assign active_o = (count != '0);
endmodule : rsrec_one_shot
`default_nettype wire

/* File: src/rsrec_top.sv */
// Reset source recorder: system manager registers with sticky reset cause flags
// Summary of operation
// - Kernel soft reset sets flag bit 7
// - Power unit wake reset sets bit 6
// - Core system reset request sets bit 5
// - Watchdog reset sets flag bit 2
// - Hardware core reset sets bit 0
// - Flags clear only by writing one
// - Upper bits 31 to 8 read zero
// - Kernel reset bit self-clears after two cycles
`include "rsrec_map.svh"
`default_nettype none
module rsrec_top #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic power_on_event_i,
  input wire logic reset_pin_event_i,
  input wire logic power_unit_event_i,
  input wire logic watchdog_event_i,
  input wire logic core_system_reset_request_i,
  output logic kernel_reset_o,
  output logic chip_reset_o,
  output logic [31:0] block_reset_two_o,
  output logic [31:0] hysteresis_a_o,
  output logic [31:0] hysteresis_b_o,
  output logic [31:0] pin_function_a_o,
  output logic [31:0] pin_function_b_o,
  output logic [31:0] wake_control_o,
  output logic irq_o
);
  initial begin
    if (ADDR_W < 9) begin
      $error("rsrec_top: ADDR_W must reach offset 0x110");
    end
  end

  // Event pins come from other reset domains, so two flops each
  logic [4:0] ev_meta;
  logic [4:0] ev_sync;
  logic [4:0] ev_prev;
  logic [4:0] ev_rise;
  always_ff @(posedge clk_i) begin
    if (clk_en_i) begin
      ev_meta <= {core_system_reset_request_i, watchdog_event_i, power_unit_event_i,
                  reset_pin_event_i, power_on_event_i};
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end
  assign ev_rise = ev_sync & ~ev_prev;

  rsrec_pkg::rsrec_bus_type bus_state;
  logic [ADDR_W-1:0] word_addr;
  logic wr_go;
  logic wr_take;
  logic rd_go;
  logic [31:0] byte_mask;
  assign word_addr = {avs_address_i[ADDR_W-1:2], 2'b00};
  assign byte_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  // Writes land only at the edge where waitrequest is low, never at the wait edge
  assign wr_take = clk_en_i && avs_write_i && (bus_state == rsrec_pkg::rsrec_idle);
  assign wr_go = clk_en_i && avs_write_i && (bus_state == rsrec_pkg::rsrec_write_done);
  assign rd_go = clk_en_i && avs_read_i && (bus_state == rsrec_pkg::rsrec_idle);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // One cycle of wait on every access, then the answer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_state <= rsrec_pkg::rsrec_idle;
    end else if (clk_en_i) begin
      case (bus_state)
        rsrec_pkg::rsrec_idle: begin
          if (avs_write_i) begin
            bus_state <= rsrec_pkg::rsrec_write_done;
          end else if (avs_read_i) begin
            bus_state <= rsrec_pkg::rsrec_read_done;
          end
        end
        default: begin
          bus_state <= rsrec_pkg::rsrec_idle;
        end
      endcase
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) &&
                             (bus_state == rsrec_pkg::rsrec_idle);

  // Flag state; the reset port here is only the recorder's own cold reset
  logic [7:0] cause;
  logic [7:0] cause_set;
  logic [7:0] cause_clr;
  logic kernel_shot;
  logic kernel_shot_q;
  logic kernel_fire;
  logic chip_fire;
  logic [31:0] brc2;
  logic [31:0] irq_stat;
  logic [31:0] irq_mask;
  logic [31:0] key;
  logic [31:0] trim;

  assign kernel_fire = wr_go && hit(word_addr, `RSREC_OFS_BRC1) && avs_byteenable_i[0] &&
                       avs_writedata_i[`RSREC_BIT_KERNEL_SHOT];
  assign chip_fire = wr_go && hit(word_addr, `RSREC_OFS_BRC1) && avs_byteenable_i[0] &&
                     avs_writedata_i[`RSREC_BIT_CHIP_SHOT];

  rsrec_one_shot #(
    .CYCLES(`RSREC_SHOT_CYCLES)
  ) u_kernel_shot (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(clk_en_i),
    .fire_i(kernel_fire),
    .active_o(kernel_shot)
  );
  logic chip_shot;
  rsrec_one_shot #(
    .CYCLES(`RSREC_SHOT_CYCLES)
  ) u_chip_shot (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(clk_en_i),
    .fire_i(chip_fire),
    .active_o(chip_shot)
  );

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      kernel_shot_q <= 1'b0;
    end else if (clk_en_i) begin
      kernel_shot_q <= kernel_shot;
    end
  end

  always_comb begin
    cause_set = 8'h00;
    cause_set[`RSREC_BIT_KERNEL] = kernel_shot & ~kernel_shot_q;
    cause_set[`RSREC_BIT_PMU] = ev_rise[2];
    cause_set[`RSREC_BIT_SYSREQ] = ev_rise[4];
    cause_set[`RSREC_BIT_WDT] = ev_rise[3];
    cause_set[`RSREC_BIT_CORE] = ev_rise[0] | ev_rise[1] | ev_rise[2] | chip_shot;
  end
  assign cause_clr = (wr_go && hit(word_addr, `RSREC_OFS_CAUSE) && avs_byteenable_i[0]) ?
                     avs_writedata_i[7:0] : 8'h00;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cause <= 8'h00;
    end else if (clk_en_i) begin
      cause <= ((cause & ~cause_clr) | cause_set) & `RSREC_CAUSE_MASK;
    end
  end

  // Interrupt status mirrors new cause events; set beats clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_stat <= `RSREC_RST_ZERO;
    end else if (clk_en_i) begin
      irq_stat <= (irq_stat & ~((wr_go && hit(word_addr, `RSREC_OFS_IRQ_STAT)) ?
                  (avs_writedata_i & byte_mask) : 32'h0000_0000)) | {24'h00_0000, cause_set};
    end
  end
  assign irq_o = |(irq_stat & irq_mask);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      brc2 <= `RSREC_RST_ZERO;
      hysteresis_a_o <= `RSREC_RST_ZERO;
      hysteresis_b_o <= `RSREC_RST_ZERO;
      pin_function_a_o <= `RSREC_RST_ZERO;
      pin_function_b_o <= `RSREC_RST_ZERO;
      wake_control_o <= `RSREC_RST_WAKE;
      irq_mask <= `RSREC_RST_ZERO;
      key <= `RSREC_RST_ZERO;
      trim <= `RSREC_RST_TRIM;
    end else if (wr_go) begin
      if (hit(word_addr, `RSREC_OFS_BRC2)) begin
        brc2 <= merge(brc2, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_HYSA)) begin
        hysteresis_a_o <= merge(hysteresis_a_o, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_HYSB)) begin
        hysteresis_b_o <= merge(hysteresis_b_o, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_PFA)) begin
        pin_function_a_o <= merge(pin_function_a_o, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_PFB)) begin
        pin_function_b_o <= merge(pin_function_b_o, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_WAKE)) begin
        wake_control_o <= merge(wake_control_o, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_IRQ_MASK)) begin
        irq_mask <= merge(irq_mask, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_KEY)) begin
        key <= merge(key, avs_writedata_i, byte_mask);
      end else if (hit(word_addr, `RSREC_OFS_TRIM)) begin
        trim <= merge(trim, avs_writedata_i, byte_mask);
      end
    end
  end
  assign block_reset_two_o = brc2;
  assign kernel_reset_o = kernel_shot;
  assign chip_reset_o = chip_shot;

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (hit(word_addr, `RSREC_OFS_CAUSE)) begin
      rd_mux = {24'h00_0000, cause};
    end else if (hit(word_addr, `RSREC_OFS_BRC1)) begin
      rd_mux = {30'h0000_0000, kernel_shot, chip_shot} & `RSREC_BRC1_MASK;
    end else if (hit(word_addr, `RSREC_OFS_BRC2)) begin
      rd_mux = brc2;
    end else if (hit(word_addr, `RSREC_OFS_HYSA)) begin
      rd_mux = hysteresis_a_o;
    end else if (hit(word_addr, `RSREC_OFS_HYSB)) begin
      rd_mux = hysteresis_b_o;
    end else if (hit(word_addr, `RSREC_OFS_PFA)) begin
      rd_mux = pin_function_a_o;
    end else if (hit(word_addr, `RSREC_OFS_PFB)) begin
      rd_mux = pin_function_b_o;
    end else if (hit(word_addr, `RSREC_OFS_WAKE)) begin
      rd_mux = wake_control_o;
    end else if (hit(word_addr, `RSREC_OFS_IRQ_STAT)) begin
      rd_mux = irq_stat;
    end else if (hit(word_addr, `RSREC_OFS_IRQ_MASK)) begin
      rd_mux = irq_mask;
    end else if (hit(word_addr, `RSREC_OFS_KEY)) begin
      rd_mux = key;
    end else if (hit(word_addr, `RSREC_OFS_TRIM)) begin
      rd_mux = trim;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data registered at the wait cycle; unmapped reads give zero and a slave error
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else if (rd_go || wr_take) begin
      avs_readdata_o <= rd_go ? rd_mux : 32'h0000_0000;
      avs_response_o <= rd_hit ? 2'h0 : 2'h2;
    end
  end

  // Assertions
  property p_kernel_flag;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && kernel_fire) ##1 clk_en_i ##1 clk_en_i |-> cause[`RSREC_BIT_KERNEL];
  endproperty
  a_kernel_flag: assert property (p_kernel_flag) else $error("kernel flag not set");

  property p_pmu_flag;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && ev_rise[2]) |=> cause[`RSREC_BIT_PMU] && cause[`RSREC_BIT_CORE];
  endproperty
  a_pmu_flag: assert property (p_pmu_flag) else $error("power unit flag not set");

  property p_sysreq_flag;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && ev_rise[4]) |=> cause[`RSREC_BIT_SYSREQ];
  endproperty
  a_sysreq_flag: assert property (p_sysreq_flag) else $error("request flag not set");

  property p_wdt_flag;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && ev_rise[3]) |=> cause[`RSREC_BIT_WDT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

  property p_core_flag;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && (ev_rise[0] || ev_rise[1])) |=> cause[`RSREC_BIT_CORE];
  endproperty
  a_core_flag: assert property (p_core_flag) else $error("core flag not set");

  property p_flag_hold;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && cause_clr == 8'h00) |=> ((cause & $past(cause)) == $past(cause));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear");

  property p_upper_zero;
    @(posedge clk_i) disable iff (reset_i)
      (bus_state == rsrec_pkg::rsrec_read_done) && $past(hit(word_addr, `RSREC_OFS_CAUSE))
      |-> avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper cause bits not zero");

  sequence s_fire;
    clk_en_i && kernel_fire;
  endsequence
  sequence s_pulse;
    (clk_en_i && kernel_shot) [*2] ##1 (clk_en_i && !kernel_shot);
  endsequence
  property p_shot_shape;
    @(posedge clk_i) disable iff (reset_i)
      s_fire ##1 (clk_en_i && !kernel_fire) [*3] |-> !kernel_shot;
  endproperty
  a_shot_shape: assert property (p_shot_shape) else $error("kernel pulse too long");

  property p_shot_start;
    @(posedge clk_i) disable iff (reset_i)
      s_fire |=> kernel_shot;
  endproperty
  a_shot_start: assert property (p_shot_start) else $error("kernel pulse missing");

  property p_recorded_survives;
    @(posedge clk_i) disable iff (reset_i)
      (clk_en_i && cause[`RSREC_BIT_WDT] && ev_rise[0] && cause_clr == 8'h00)
      |=> cause[`RSREC_BIT_WDT];
  endproperty
  a_recorded_survives: assert property (p_recorded_survives) else $error("flag wiped");
endmodule : rsrec_top
`default_nettype wire

/* File: bench/rsrec_top_tb.sv */
// Self-checking bench for the reset source recorder
`include "rsrec_map.svh"
`default_nettype none
module rsrec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, clk_en_i, rd_i, wr_i, wreq, kro, cro, irq;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, got, rr;
  logic [31:0] brc2_o, hya_o, hyb_o, pfa_o, pfb_o, wake_o;
  logic [3:0] be;
  logic [1:0] rsp, gr;
  logic [4:0] ev;
  int error_cnt = 0, checks = 0, seed = 75067, kcnt = 0, ccnt = 0, k0;
  logic [31:0] cause_m = 0, stat_m = 0;
  logic [31:0] mdl [8];
  logic [7:0] evm [5] = '{8'h01, 8'h01, 8'h41, 8'h04, 8'h20};
  logic [11:0] all_ofs [12] = '{`RSREC_OFS_CAUSE, `RSREC_OFS_BRC1, `RSREC_OFS_BRC2,
    `RSREC_OFS_HYSA, `RSREC_OFS_HYSB, `RSREC_OFS_PFA, `RSREC_OFS_PFB, `RSREC_OFS_WAKE,
    `RSREC_OFS_IRQ_STAT, `RSREC_OFS_IRQ_MASK, `RSREC_OFS_KEY, `RSREC_OFS_TRIM};
  logic [11:0] rw_ofs [8] = '{`RSREC_OFS_BRC2, `RSREC_OFS_HYSA, `RSREC_OFS_HYSB,
    `RSREC_OFS_PFA, `RSREC_OFS_PFB, `RSREC_OFS_WAKE, `RSREC_OFS_KEY, `RSREC_OFS_TRIM};

  rsrec_top #(.ADDR_W(12)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .avs_address_i(adr), .avs_read_i(rd_i), .avs_write_i(wr_i),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .avs_response_o(rsp),
    .power_on_event_i(ev[0]), .reset_pin_event_i(ev[1]), .power_unit_event_i(ev[2]),
    .watchdog_event_i(ev[3]), .core_system_reset_request_i(ev[4]),
    .kernel_reset_o(kro), .chip_reset_o(cro), .block_reset_two_o(brc2_o),
    .hysteresis_a_o(hya_o), .hysteresis_b_o(hyb_o), .pin_function_a_o(pfa_o),
    .pin_function_b_o(pfb_o), .wake_control_o(wake_o), .irq_o(irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Count one-shot pulse width in cycles, sampled away from the edge
  always @(negedge clk_i) begin
    if (kro === 1'b1) kcnt++;
    if (cro === 1'b1) ccnt++;
  end

  task automatic wrap_up();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request is held until waitrequest is seen low, then released after that edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    adr <= a;
    wdat <= d;
    be <= b;
    wr_i <= w;
    rd_i <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wreq === 1'b0) break;
    end
    if (n == 20) begin
      chk("waitrequest", 32'h1, 32'h0);
      wrap_up();
    end
    got = rdat;
    gr = rsp;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk("readdata", got, exp);
    chk("response", {30'h0, gr}, {30'h0, er});
  endtask : rdc

  task automatic fire(input int i);
    ev[i] <= 1'b1;
    repeat (3) @(posedge clk_i);
    ev[i] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : fire

  initial begin
    #400000;
    chk("run length", 32'h1, 32'h0);
    wrap_up();
  end

  initial begin
    clk_en_i = 1'b1;
    reset_i = 1'b1;
    rd_i = 1'b0;
    wr_i = 1'b0;
    adr = 12'h000;
    wdat = 32'h0000_0000;
    be = 4'h0;
    ev = 5'h00;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (all_ofs[i]) begin
      rdc(all_ofs[i], (all_ofs[i] == `RSREC_OFS_WAKE) ? `RSREC_RST_WAKE : 32'h0, 2'b00);
    end
    rdc(12'h0FC, 32'h0000_0000, 2'b10);
    bus(1'b1, `RSREC_OFS_CAUSE, 32'hFFFF_FFFF, 4'hF);
    rdc(`RSREC_OFS_CAUSE, 32'h0000_0000, 2'b00);
    for (int i = 0; i < 5; i++) begin
      fire(i);
      cause_m |= evm[i];
      stat_m |= evm[i];
      rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    end
    // Zero writes and writes without lane 0 must leave flags alone
    bus(1'b1, `RSREC_OFS_CAUSE, 32'h0000_0000, 4'hF);
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    bus(1'b1, `RSREC_OFS_CAUSE, 32'h0000_00FF, 4'hE);
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    bus(1'b1, `RSREC_OFS_CAUSE, 32'h0000_0004, 4'hF);
    cause_m &= ~32'h4;
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    chk("irq", {31'h0, irq}, 32'h0);
    bus(1'b1, `RSREC_OFS_IRQ_MASK, 32'h0000_0020, 4'hF);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, `RSREC_OFS_IRQ_STAT, 32'h0000_0020, 4'hF);
    stat_m &= ~32'h20;
    chk("irq", {31'h0, irq}, 32'h0);
    rdc(`RSREC_OFS_IRQ_STAT, stat_m, 2'b00);
    k0 = kcnt;
    bus(1'b1, `RSREC_OFS_BRC1, 32'h0000_0002, 4'hF);
    repeat (8) @(posedge clk_i);
    chk("kernel pulse", k0 - kcnt + 2 * (kcnt - k0), 32'd2);
    cause_m |= 32'h80;
    rdc(`RSREC_OFS_BRC1, 32'h0000_0000, 2'b00);
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    bus(1'b1, `RSREC_OFS_CAUSE, 32'h0000_0001, 4'hF);
    cause_m &= ~32'h1;
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    k0 = ccnt;
    bus(1'b1, `RSREC_OFS_BRC1, 32'h0000_0001, 4'hF);
    repeat (8) @(posedge clk_i);
    chk("chip pulse", ccnt - k0, 32'd2);
    cause_m |= 32'h1;
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    repeat (2) begin
      foreach (rw_ofs[i]) begin
        rr = $random(seed);
        mdl[i] = rr;
        bus(1'b1, rw_ofs[i], rr, 4'hF);
        rdc(rw_ofs[i], mdl[i], 2'b00);
      end
    end
    chk("block_reset_two", brc2_o, mdl[0]);
    chk("hysteresis_a", hya_o, mdl[1]);
    chk("hysteresis_b", hyb_o, mdl[2]);
    chk("pin_function_a", pfa_o, mdl[3]);
    chk("pin_function_b", pfb_o, mdl[4]);
    chk("wake_control", wake_o, mdl[5]);
    bus(1'b1, 12'h0FC, 32'hFFFF_FFFF, 4'hF);
    chk("response", {30'h0, gr}, 32'h2);
    rdc(`RSREC_OFS_CAUSE, cause_m, 2'b00);
    wrap_up();
  end
endmodule : rsrec_top_tb
`default_nettype wire
